// File: hw/sam_alarm_eval.sv
// One setpoint alarm: comparisons, delay counting and event capture
`timescale 1ns/1ps
module sam_alarm_eval (
	// Clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              tick_i,
	// Setup and measurement
	input  wire sam_pkg::sam_cfg_t  cfg_i,
	input  wire sam_pkg::sam_meas_t meas_i,
	// Event hand-off
	input  wire logic              grant_i,
	output logic                   active_o,
	output logic                   evt_valid_o,
	output sam_pkg::sam_evt_t      evt_kind_o,
	output sam_pkg::sam_meas_t     evt_meas_o
);
	import sam_pkg::*;

	sam_state_t       state_q;
	logic [DLY_W-1:0] cnt_q;
	logic             pu_over;
	logic             do_over;
	logic             pu_cond;
	logic             do_cond;
	logic             qual;
	logic [DLY_W-1:0] lim;
	logic             fire;

	assign pu_over = cfg_i.is_pf ? cfg_i.pickup_pf_quadrant_select : cfg_i.over_sel; // [RULE_05]
	assign do_over = cfg_i.is_pf ? cfg_i.dropout_pf_quadrant_select : cfg_i.over_sel; // [RULE_05]
	assign pu_cond = pu_over ? (meas_i.value > cfg_i.pickup_set)
		: (meas_i.value < cfg_i.pickup_set); // [RULE_03]
	assign do_cond = do_over ? (meas_i.value < cfg_i.dropout_set)
		: (meas_i.value > cfg_i.dropout_set); // [RULE_04]

	always_comb begin
		unique case (state_q)
			ST_IDLE: begin
				qual = pu_cond;
				lim  = cfg_i.pickup_dly;
			end
			ST_ACTIVE: begin
				qual = do_cond;
				lim  = cfg_i.dropout_dly;
			end
			default: begin
				qual = 1'b0;
				lim  = '0;
			end
		endcase
		// Out-of-range settings are held at the longest legal delay
		if (lim > DLY_MAX) begin
			lim = DLY_MAX;
		end
	end

	assign fire = tick_i && qual && (cnt_q >= lim); // [RULE_23]

	// Delay counting on the one-second tick; a false sample restarts it
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || !cfg_i.enable) begin // [RULE_01]
			state_q <= ST_IDLE;
			cnt_q   <= '0;
		end else if (tick_i) begin
			if (fire) begin
				state_q <= (state_q == ST_IDLE) ? ST_ACTIVE : ST_IDLE; // [RULE_03] [RULE_04]
				cnt_q   <= '0;
			end else if (qual) begin
				cnt_q <= cnt_q + 1'b1; // [RULE_22]
			end else begin
				cnt_q <= '0; // [RULE_22]
			end
		end
	end

	// Pending event waits for its grant; a new one overwrites it
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || !cfg_i.enable) begin // [RULE_01]
			evt_valid_o <= 1'b0;
			evt_kind_o  <= EVT_NONE;
			evt_meas_o  <= '0;
		end else if (fire) begin
			evt_valid_o <= 1'b1;
			evt_kind_o  <= (state_q == ST_IDLE) ? EVT_PICKUP : EVT_DROPOUT;
			evt_meas_o  <= meas_i;
		end else if (grant_i) begin
			evt_valid_o <= 1'b0;
		end
	end

	assign active_o = (state_q == ST_ACTIVE);

	AST_DISABLED_IDLE: // [RULE_01]
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!cfg_i.enable |=> !active_o && !evt_valid_o)
		else $error("disabled alarm still active");
	AST_TRIP_CAUSE: // [RULE_03]
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(active_o) |-> $past(tick_i) && $past(pu_cond) && $past(cnt_q >= lim))
		else $error("trip without pickup condition held");
	AST_DELAY_RESTART: // [RULE_22]
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		tick_i && !qual && cfg_i.enable |=> cnt_q == '0)
		else $error("delay count not restarted");
	AST_DROP_CAUSE: // [RULE_04]
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$fell(active_o) && $past(cfg_i.enable) |-> $past(do_cond) && $past(tick_i))
		else $error("alarm ended without dropout condition");
endmodule

// File: hw/sam_monitor.sv
// Setpoint alarm monitor: evaluators, notification, rings and counters
//
// Notes on behaviour
// [RULE_01] Disabled alarm never trips, drives or records
// [RULE_02] Priority selects notification and recording
// [RULE_03] Trip after pickup condition holds pickup delay
// [RULE_04] End after dropout condition holds dropout delay
// [RULE_05] Power factor: lead means over, lag under
// [RULE_06] Output select drives relay one, two, both
// [RULE_07] LED blinks for alarms in alarm mode
// [RULE_08] Icon lit by low, medium, high alarms
// [RULE_09] High alarm icon held until acknowledged
// [RULE_10] Active list: 40-entry ring, oldest overwritten
// [RULE_11] Active list empty after every device reset
// [RULE_12] History: 40-entry ring surviving device reset
// [RULE_13] Alarm end writes history, drops notification
// [RULE_14] Entries by time order, newest first
// [RULE_15] Record: stamp, event kind, phase, value
// [RULE_16] Priority none leaves no list records
// [RULE_17] Acknowledge offered for unacknowledged high alarms
// [RULE_18] Per-alarm occurrence counter counts each pickup
// [RULE_19] Counter wraps to zero after 9999
// [RULE_20] Clear command clears only selected data
// [RULE_21] Medium, low need no ack; none event-log only
// [RULE_22] Delays count one-second ticks, restart on false
// [RULE_23] Comparisons once per second on latest value
`timescale 1ns/1ps
module sam_monitor #(
	parameter int N_ALARM       = sam_pkg::NUM_ALARMS,
	parameter int TICK_CYCLES_P = sam_pkg::TICK_CYCLES
) (
	// Clock and resets
	input  wire logic                                    sys_clk_i,
	input  wire logic                                    rst_n_i,
	input  wire logic                                    nv_clr_n_i,
	// Setup
	input  wire sam_pkg::sam_cfg_t  [N_ALARM-1:0]        cfg_i,
	input  wire logic                                    led_alarm_mode_i,
	// Measurement and time
	input  wire sam_pkg::sam_meas_t [N_ALARM-1:0]        meas_i,
	input  wire logic [sam_pkg::TS_W-1:0]                time_now_i,
	// Operator commands
	input  wire logic [N_ALARM-1:0]                      ack_i,
	input  wire logic                                    clr_cmd_i,
	input  wire sam_pkg::sam_clr_t                       clr_sel_i,
	input  wire logic [sam_pkg::PTR_W-1:0]               rd_idx_i,
	// Notification
	output logic                                         relay_output_one_o,
	output logic                                         relay_output_two_o,
	output logic                                         icon_o,
	output logic                                         led_o,
	output logic [N_ALARM-1:0]                           ack_offer_o,
	output logic [N_ALARM-1:0]                           alarm_active_o,
	// Records and counters
	output sam_pkg::sam_rec_t                            act_rec_o,
	output logic                                         act_rec_valid_o,
	output logic [sam_pkg::PTR_W-1:0]                    act_count_o,
	output sam_pkg::sam_rec_t                            hist_rec_o,
	output logic                                         hist_rec_valid_o,
	output logic [sam_pkg::PTR_W-1:0]                    hist_count_o,
	output logic [N_ALARM-1:0][sam_pkg::CNT_W-1:0]       alarm_count_o,
	output logic                                         gen_evt_valid_o,
	output sam_pkg::sam_rec_t                            gen_evt_rec_o
);
	import sam_pkg::*;

	if (N_ALARM < 1 || N_ALARM > (1 << ID_W)) begin : g_bad_n
		$error("N_ALARM out of range");
	end
	if (TICK_CYCLES_P < 1) begin : g_bad_tick
		$error("TICK_CYCLES_P must be at least one");
	end

	function automatic logic [ID_W-1:0] first_set(input logic [N_ALARM-1:0] v);
		first_set = '0;
		for (int k = N_ALARM - 1; k >= 0; k--) begin
			if (v[k]) begin
				first_set = ID_W'(k);
			end
		end
	endfunction

	function automatic logic [PTR_W-1:0] ring_next(input logic [PTR_W-1:0] p);
		ring_next = (p == PTR_W'(RING_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// Newest entry sits just behind the write pointer
	function automatic logic [PTR_W-1:0] ring_addr(input logic [PTR_W-1:0] wp,
		input logic [PTR_W-1:0] idx);
		logic [PTR_W:0] a;
		a = {1'b0, wp} + (PTR_W + 1)'(RING_DEPTH - 1) - {1'b0, idx};
		if (a >= (PTR_W + 1)'(RING_DEPTH)) begin
			a = a - (PTR_W + 1)'(RING_DEPTH);
		end
		ring_addr = a[PTR_W-1:0];
	endfunction

	logic [31:0]             tick_cnt_q;
	logic                    tick;
	logic [N_ALARM-1:0]      active;
	logic [N_ALARM-1:0]      evt_valid;
	sam_evt_t  [N_ALARM-1:0] evt_kind;
	sam_meas_t [N_ALARM-1:0] evt_meas;
	logic [N_ALARM-1:0]      grant;
	logic                    any_evt;
	logic [ID_W-1:0]         sel;
	sam_prio_t               sel_prio;
	sam_rec_t                rec;
	logic                    act_wr;
	logic                    hist_wr;
	logic [N_ALARM-1:0]      nonnone;
	logic [N_ALARM-1:0]      relay_one_vec;
	logic [N_ALARM-1:0]      relay_two_vec;
	logic [N_ALARM-1:0]      unack_q;
	logic                    blink_q;
	sam_rec_t                act_mem [RING_DEPTH];
	sam_rec_t                hist_mem [RING_DEPTH];
	logic [PTR_W-1:0]        act_wp_q;
	logic [PTR_W-1:0]        act_cnt_q;
	logic [PTR_W-1:0]        hist_wp_q;
	logic [PTR_W-1:0]        hist_cnt_q;
	logic [N_ALARM-1:0][CNT_W-1:0] cnt_q;

	// One-second tick from the system clock
	assign tick = (tick_cnt_q == 32'(TICK_CYCLES_P - 1));

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h1; // [RULE_22]
		end
	end

	for (genvar g = 0; g < N_ALARM; g++) begin : g_alarm
		sam_alarm_eval u_eval (
			.sys_clk_i  (sys_clk_i),
			.rst_n_i    (rst_n_i),
			.tick_i     (tick),
			.cfg_i      (cfg_i[g]),
			.meas_i     (meas_i[g]),
			.grant_i    (grant[g]),
			.active_o   (active[g]),
			.evt_valid_o(evt_valid[g]),
			.evt_kind_o (evt_kind[g]),
			.evt_meas_o (evt_meas[g])
		);
		assign nonnone[g]       = active[g] && (cfg_i[g].prio != PRIO_NONE); // [RULE_08]
		assign relay_one_vec[g] = active[g] && cfg_i[g].out_sel[OUT_BIT_ONE]; // [RULE_06]
		assign relay_two_vec[g] = active[g] && cfg_i[g].out_sel[OUT_BIT_TWO]; // [RULE_06]
	end

	// Simultaneous events drain lowest index first, one per cycle
	assign any_evt  = |evt_valid;
	assign sel      = first_set(evt_valid);
	assign grant    = any_evt ? (N_ALARM'(1) << sel) : '0;
	assign sel_prio = cfg_i[sel].prio;

	always_comb begin
		rec          = '0;
		rec.stamp    = time_now_i; // [RULE_15]
		rec.alarm_id = sel;
		rec.kind     = evt_kind[sel];
		rec.phase    = evt_meas[sel].phase;
		rec.value    = evt_meas[sel].value;
	end

	assign act_wr  = any_evt && (sel_prio != PRIO_NONE) && (rec.kind == EVT_PICKUP); // [RULE_16]
	assign hist_wr = any_evt && (sel_prio != PRIO_NONE) && (rec.kind == EVT_DROPOUT); // [RULE_13]

	// Active list: volatile, emptied by device reset
	always_ff @(posedge sys_clk_i) begin
		if (act_wr) begin
			act_mem[act_wp_q] <= rec; // [RULE_10]
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			act_wp_q  <= '0; // [RULE_11]
			act_cnt_q <= '0;
		end else if (act_wr) begin
			act_wp_q <= ring_next(act_wp_q); // [RULE_10]
			if (clr_cmd_i && clr_sel_i.act_list) begin
				act_cnt_q <= PTR_W'(1);
			end else if (act_cnt_q != PTR_W'(RING_DEPTH)) begin
				act_cnt_q <= act_cnt_q + 1'b1;
			end
		end else if (clr_cmd_i && clr_sel_i.act_list) begin
			act_cnt_q <= '0; // [RULE_20]
		end
	end

	// History log keeps its contents and pointers across device reset
	always_ff @(posedge sys_clk_i) begin
		if (hist_wr) begin
			hist_mem[hist_wp_q] <= rec; // [RULE_12]
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nv_clr_n_i) begin
			hist_wp_q  <= '0;
			hist_cnt_q <= '0;
		end else if (hist_wr) begin
			hist_wp_q <= ring_next(hist_wp_q); // [RULE_12]
			if (clr_cmd_i && clr_sel_i.hist_log) begin
				hist_cnt_q <= PTR_W'(1);
			end else if (hist_cnt_q != PTR_W'(RING_DEPTH)) begin
				hist_cnt_q <= hist_cnt_q + 1'b1;
			end
		end else if (clr_cmd_i && clr_sel_i.hist_log) begin
			hist_cnt_q <= '0; // [RULE_20]
		end
	end

	// Occurrence counters; a pickup in the same cycle as a clear leaves a count of one
	always_ff @(posedge sys_clk_i) begin
		if (!nv_clr_n_i) begin
			cnt_q <= '0;
		end else begin
			for (int k = 0; k < N_ALARM; k++) begin
				if (grant[k] && evt_kind[k] == EVT_PICKUP) begin
					if (clr_cmd_i && clr_sel_i.counters) begin
						cnt_q[k] <= CNT_W'(1);
					end else if (cnt_q[k] >= CNT_WRAP) begin
						cnt_q[k] <= '0; // [RULE_19]
					end else begin
						cnt_q[k] <= cnt_q[k] + 1'b1; // [RULE_18]
					end
				end else if (clr_cmd_i && clr_sel_i.counters) begin
					cnt_q[k] <= '0; // [RULE_20]
				end
			end
		end
	end

	// Acknowledge latch only for high priority; a new pickup beats the ack
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			unack_q <= '0;
		end else begin
			for (int k = 0; k < N_ALARM; k++) begin
				if (!cfg_i[k].enable) begin
					unack_q[k] <= 1'b0; // [RULE_01]
				end else if (grant[k] && evt_kind[k] == EVT_PICKUP
					&& cfg_i[k].prio == PRIO_HIGH) begin
					unack_q[k] <= 1'b1; // [RULE_09] [RULE_21]
				end else if (ack_i[k]) begin
					unack_q[k] <= 1'b0; // [RULE_17]
				end
			end
		end
	end

	// Notification outputs; the blink phase steps on the tick
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			blink_q            <= 1'b0;
			icon_o             <= 1'b0;
			led_o              <= 1'b0;
			relay_output_one_o <= 1'b0;
			relay_output_two_o <= 1'b0;
		end else begin
			blink_q            <= (|nonnone) ? (blink_q ^ tick) : 1'b0;
			icon_o             <= (|nonnone) || (|unack_q); // [RULE_08] [RULE_09] [RULE_13]
			led_o              <= led_alarm_mode_i && (|nonnone) && blink_q; // [RULE_07] [RULE_02]
			relay_output_one_o <= |relay_one_vec; // [RULE_06]
			relay_output_two_o <= |relay_two_vec;
		end
	end

	// Readback, newest first, plus the general event stream
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			act_rec_o        <= '0;
			act_rec_valid_o  <= 1'b0;
			hist_rec_o       <= '0;
			hist_rec_valid_o <= 1'b0;
			gen_evt_valid_o  <= 1'b0;
			gen_evt_rec_o    <= '0;
		end else begin
			act_rec_o        <= act_mem[ring_addr(act_wp_q, rd_idx_i)]; // [RULE_14]
			act_rec_valid_o  <= rd_idx_i < act_cnt_q;
			hist_rec_o       <= hist_mem[ring_addr(hist_wp_q, rd_idx_i)]; // [RULE_14]
			hist_rec_valid_o <= rd_idx_i < hist_cnt_q;
			gen_evt_valid_o  <= any_evt; // [RULE_21]
			gen_evt_rec_o    <= rec;
		end
	end

	assign ack_offer_o    = unack_q; // [RULE_17]
	assign alarm_active_o = active;
	assign act_count_o    = act_cnt_q;
	assign hist_count_o   = hist_cnt_q;
	assign alarm_count_o  = cnt_q;

	AST_ICON_QUIET: // [RULE_08]
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!(|nonnone) && !(|unack_q) |=> !icon_o)
		else $error("icon lit without qualifying alarm");
	AST_HIGH_HOLD: // [RULE_09]
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(|unack_q) |=> icon_o)
		else $error("icon dropped before acknowledge");
	AST_LED_MODE: // [RULE_07]
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!led_alarm_mode_i |=> !led_o)
		else $error("LED blinking outside alarm mode");
	AST_RELAY_ONE: // [RULE_06]
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(|relay_one_vec) |=> relay_output_one_o)
		else $error("relay one not driven");
	AST_ACT_EMPTY: // [RULE_11]
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> act_count_o == '0)
		else $error("active list not empty after reset");
	AST_NONE_NO_REC: // [RULE_16]
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		any_evt && sel_prio == PRIO_NONE && !clr_cmd_i |=> $stable(act_count_o))
		else $error("priority none alarm recorded");
	AST_CNT_WRAP: // [RULE_19]
	assert property (@(posedge sys_clk_i) disable iff (!nv_clr_n_i)
		grant[0] && evt_kind[0] == EVT_PICKUP && !clr_cmd_i
		|=> cnt_q[0] == (($past(cnt_q[0]) == CNT_WRAP) ? CNT_W'(0) : $past(cnt_q[0]) + 1'b1))
		else $error("counter did not step or wrap");
	AST_ACK_CLEAR: // [RULE_17]
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ack_i[0] && unack_q[0] && !grant[0] |=> !ack_offer_o[0])
		else $error("acknowledge did not clear");
endmodule

// File: hw/sam_pkg.sv
// Shared constants and types for the setpoint alarm monitor
package sam_pkg;
	localparam int VAL_W          = 32;
	localparam int DLY_W          = 20;
	localparam int TS_W           = 32;
	localparam int CNT_W          = 14;
	localparam int ID_W           = 4;
	localparam int PH_W           = 2;
	localparam int NUM_ALARMS     = 4;
	localparam int RING_DEPTH     = 40;
	localparam int PTR_W          = $clog2(RING_DEPTH + 1);
	localparam int CLK_HZ         = 100_000_000;
	localparam int TICK_PERIOD_S  = 1;
	localparam int TICK_CYCLES    = CLK_HZ * TICK_PERIOD_S;
	localparam int OUT_BIT_ONE    = 0;
	localparam int OUT_BIT_TWO    = 1;
	localparam logic [DLY_W-1:0] DLY_MAX  = 20'hf423f;
	localparam logic [CNT_W-1:0] CNT_WRAP = 14'h270f;

	typedef enum logic [1:0] {
		PRIO_NONE = 2'h0,
		PRIO_LOW  = 2'h1,
		PRIO_MED  = 2'h2,
		PRIO_HIGH = 2'h3
	} sam_prio_t;

	typedef enum logic [1:0] {
		EVT_NONE    = 2'h0,
		EVT_PICKUP  = 2'h1,
		EVT_DROPOUT = 2'h2,
		EVT_UNARY   = 2'h3
	} sam_evt_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b01,
		ST_ACTIVE = 2'b10
	} sam_state_t;

	// Output select: bit 0 drives relay one, bit 1 relay two
	typedef struct packed {
		logic             enable;
		sam_prio_t        prio;
		logic             over_sel;
		logic             is_pf;
		logic             pickup_pf_quadrant_select;
		logic             dropout_pf_quadrant_select;
		logic [1:0]       out_sel;
		logic [VAL_W-1:0] pickup_set;
		logic [VAL_W-1:0] dropout_set;
		logic [DLY_W-1:0] pickup_dly;
		logic [DLY_W-1:0] dropout_dly;
	} sam_cfg_t;

	typedef struct packed {
		logic [PH_W-1:0]  phase;
		logic [VAL_W-1:0] value;
	} sam_meas_t;

	typedef struct packed {
		logic [TS_W-1:0]  stamp;
		logic [ID_W-1:0]  alarm_id;
		sam_evt_t         kind;
		logic [PH_W-1:0]  phase;
		logic [VAL_W-1:0] value;
	} sam_rec_t;

	typedef struct packed {
		logic act_list;
		logic hist_log;
		logic counters;
	} sam_clr_t;
endpackage

// File: tb/sam_monitor_bench.sv
// Self-checking bench for the setpoint alarm monitor
`timescale 1ns/1ps
module sam_monitor_bench;
	import sam_pkg::*;
	// Short tick keeps the second-based delays cheap to simulate
	localparam int T = 10;
	localparam int N = 4;
	logic                    sys_clk_i;
	logic                    rst_n_i;
	logic                    nv_clr_n_i;
	logic                    led_mode;
	logic                    clr_cmd;
	sam_cfg_t  [N-1:0]       cfg;
	sam_meas_t [N-1:0]       meas;
	logic [TS_W-1:0]         now;
	logic [N-1:0]            ack;
	sam_clr_t                clr_sel;
	logic [PTR_W-1:0]        rd_idx;
	logic                    relay_one;
	logic                    relay_two;
	logic                    icon;
	logic                    led;
	logic                    act_v;
	logic                    hist_v;
	logic                    gen_v;
	logic [N-1:0]            offer;
	logic [N-1:0]            active;
	sam_rec_t                act_rec;
	sam_rec_t                hist_rec;
	sam_rec_t                gen_rec;
	logic [PTR_W-1:0]        act_cnt;
	logic [PTR_W-1:0]        hist_cnt;
	logic [N-1:0][CNT_W-1:0] acount;
	int                      num_errors = 0;
	int                      check_count = 0;

	sam_monitor #(.N_ALARM(N), .TICK_CYCLES_P(T)) i_dut (
		.sys_clk_i          (sys_clk_i),
		.rst_n_i            (rst_n_i),
		.nv_clr_n_i         (nv_clr_n_i),
		.cfg_i              (cfg),
		.led_alarm_mode_i   (led_mode),
		.meas_i             (meas),
		.time_now_i         (now),
		.ack_i              (ack),
		.clr_cmd_i          (clr_cmd),
		.clr_sel_i          (clr_sel),
		.rd_idx_i           (rd_idx),
		.relay_output_one_o (relay_one),
		.relay_output_two_o (relay_two),
		.icon_o             (icon),
		.led_o              (led),
		.ack_offer_o        (offer),
		.alarm_active_o     (active),
		.act_rec_o          (act_rec),
		.act_rec_valid_o    (act_v),
		.act_count_o        (act_cnt),
		.hist_rec_o         (hist_rec),
		.hist_rec_valid_o   (hist_v),
		.hist_count_o       (hist_cnt),
		.alarm_count_o      (acount),
		.gen_evt_valid_o    (gen_v),
		.gen_evt_rec_o      (gen_rec)
	);

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	task automatic chk1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	// Bounded wait, so a stuck alarm shows up as a late count
	task automatic wait_act(input int k, input logic lvl, output int c);
		c = 0;
		while (active[k] !== lvl && c < 5 * T) begin
			@(negedge sys_clk_i);
			c++;
		end
	endtask

	task automatic set_cfg(input int k, input sam_prio_t p, input logic pf, input logic [1:0] o,
			input logic [31:0] pu, input logic [31:0] du, input logic [19:0] pd,
			input logic [19:0] dd);
		cfg[k] = '{1'b1, p, 1'b1, pf, 1'b0, 1'b0, o, pu, du, pd, dd};
	endtask

	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic t_reset;
		cyc(2);
		chkv(act_cnt, 32'h0);
		chk1(icon, 1'b0);
		chk1(relay_one, 1'b0);
		chkv(acount[0], 32'h0);
		$display("Test reset done");
	endtask

	task automatic t_pickup;
		int c;
		logic l;
		now = 32'h0000_0100;
		set_cfg(0, PRIO_HIGH, 1'b0, 2'b01, 32'hc8, 32'h64, 20'h2, 20'h1);
		meas[0] = '{2'h1, 32'h12c};
		cyc(2 * T);
		chk1(active[0], 1'b0);
		meas[0].value = 32'h96;
		cyc(T + 1);
		meas[0].value = 32'h12c;
		wait_act(0, 1'b1, c);
		chk1(c > 2 * T && c <= 3 * T, 1'b1);
		cyc(4);
		chk1(relay_one, 1'b1);
		chk1(relay_two, 1'b0);
		chk1(icon, 1'b1);
		chk1(offer[0], 1'b1);
		chkv(act_cnt, 32'h1);
		chkv(acount[0], 32'h1);
		chkv(act_rec.value, 32'h12c);
		chkv(act_rec.kind, EVT_PICKUP);
		chkv(act_rec.phase, 32'h1);
		chkv(act_rec.stamp, 32'h100);
		l = led;
		cyc(T);
		chk1(led, ~l);
		$display("Test pickup done");
	endtask

	task automatic t_dropout;
		int c;
		now = 32'h0000_0200;
		meas[0].value = 32'h32;
		wait_act(0, 1'b0, c);
		chk1(c > T && c <= 2 * T, 1'b1);
		cyc(4);
		chk1(relay_one, 1'b0);
		chk1(led, 1'b0);
		chk1(icon, 1'b1);
		chkv(hist_cnt, 32'h1);
		chkv(hist_rec.kind, EVT_DROPOUT);
		chkv(hist_rec.stamp, 32'h200);
		ack[0] = 1'b1;
		cyc(1);
		ack[0] = 1'b0;
		cyc(2);
		chk1(offer[0], 1'b0);
		chk1(icon, 1'b0);
		$display("Test dropout done");
	endtask

	task automatic t_none;
		int c;
		set_cfg(1, PRIO_NONE, 1'b0, 2'b00, 32'hc8, 32'h64, 20'h0, 20'h0);
		cfg[2] = '{1'b0, PRIO_HIGH, 1'b1, 1'b0, 1'b0, 1'b0, 2'b11, 32'hc8, 32'h64, 20'h0, 20'h0};
		meas[1].value = 32'h12c;
		meas[2].value = 32'h12c;
		wait_act(1, 1'b1, c);
		cyc(1);
		chk1(gen_v, 1'b1);
		chkv(gen_rec.alarm_id, 32'h1);
		chkv(gen_rec.kind, EVT_PICKUP);
		cyc(3);
		chk1(active[1], 1'b1);
		chk1(icon, 1'b0);
		chk1(led, 1'b0);
		chk1(offer[1], 1'b0);
		chkv(act_cnt, 32'h1);
		chkv(acount[1], 32'h1);
		chk1(active[2], 1'b0);
		chk1(relay_two, 1'b0);
		chkv(acount[2], 32'h0);
		meas[1].value = 32'h32;
		wait_act(1, 1'b0, c);
		cyc(4);
		chkv(hist_cnt, 32'h1);
		$display("Test none and disabled done");
	endtask

	task automatic t_pf;
		int c;
		set_cfg(3, PRIO_MED, 1'b1, 2'b10, 32'h32, 32'h50, 20'h0, 20'h0);
		meas[3].value = 32'ha;
		wait_act(3, 1'b1, c);
		cyc(4);
		chk1(active[3], 1'b1);
		chk1(relay_two, 1'b1);
		chk1(relay_one, 1'b0);
		chk1(icon, 1'b1);
		chk1(offer[3], 1'b0);
		chkv(act_cnt, 32'h2);
		meas[3].value = 32'h5a;
		wait_act(3, 1'b0, c);
		cyc(4);
		chk1(active[3], 1'b0);
		chkv(hist_cnt, 32'h2);
		clr_sel = 3'b100;
		clr_cmd = 1'b1;
		cyc(1);
		clr_cmd = 1'b0;
		cyc(2);
		chkv(act_cnt, 32'h0);
		chkv(hist_cnt, 32'h2);
		chkv(acount[3], 32'h1);
		$display("Test power factor done");
	endtask

	task automatic t_ring;
		int c;
		set_cfg(0, PRIO_LOW, 1'b0, 2'b01, 32'hc8, 32'h64, 20'h0, 20'h0);
		for (int i = 0; i < 41; i++) begin
			meas[0].value = 32'h12c + i;
			wait_act(0, 1'b1, c);
			meas[0].value = 32'h32;
			wait_act(0, 1'b0, c);
		end
		cyc(4);
		chkv(act_cnt, 32'd40);
		chkv(hist_cnt, 32'd40);
		chkv(act_rec.value, 32'h12c + 40);
		rd_idx = 6'h1;
		cyc(2);
		chkv(act_rec.value, 32'h12c + 39);
		rd_idx = 6'd39;
		cyc(2);
		chkv(act_rec.value, 32'h12d);
		rd_idx = 6'd40;
		cyc(2);
		chk1(act_v, 1'b0);
		rd_idx = 6'h0;
		cyc(2);
		chkv(acount[0], 32'd42);
		$display("Test rings done");
	endtask

	task automatic t_clear;
		clr_sel = 3'b001;
		clr_cmd = 1'b1;
		cyc(1);
		clr_cmd = 1'b0;
		cyc(2);
		chkv(acount[0], 32'h0);
		chkv(acount[3], 32'h0);
		chkv(act_cnt, 32'd40);
		chkv(hist_cnt, 32'd40);
		rst_n_i = 1'b0;
		cyc(5);
		rst_n_i = 1'b1;
		cyc(3);
		chkv(act_cnt, 32'h0);
		chkv(hist_cnt, 32'd40);
		chk1(hist_v, 1'b1);
		chkv(hist_rec.kind, EVT_DROPOUT);
		clr_sel = 3'b010;
		clr_cmd = 1'b1;
		cyc(1);
		clr_cmd = 1'b0;
		cyc(2);
		chkv(hist_cnt, 32'h0);
		chk1(hist_v, 1'b0);
		$display("Test clear and reset done");
	endtask

	initial begin
		#100000;
		num_errors++;
		give_verdict();
	end

	initial begin
		rst_n_i = 1'b0;
		nv_clr_n_i = 1'b0;
		led_mode = 1'b1;
		clr_cmd = 1'b0;
		clr_sel = 3'b000;
		cfg = '0;
		meas = '0;
		for (int k = 0; k < N; k++) begin
			meas[k].value = 32'h96;
		end
		now = 32'h0;
		ack = '0;
		rd_idx = 6'h0;
		cyc(5);
		rst_n_i = 1'b1;
		nv_clr_n_i = 1'b1;
		t_reset();
		t_pickup();
		t_dropout();
		t_none();
		t_pf();
		t_ring();
		t_clear();
		give_verdict();
	end
endmodule
